// ==== bru_byte_rotate_unit.v ====
`timescale 1ns/1ps
`include "bru_defs.vh"

module bru_byte_rotate_unit #(
    parameter WIDTH = 8
) (
    input wire clk,
    input wire nrst,
    input wire op_valid,
    input wire [`BRU_OP_W-1:0] op_sel,
    input wire [WIDTH-1:0] mem_operand,
    input wire carry_flag,
    output reg [WIDTH-1:0] accumulator_register,
    output reg acc_write_q,
    output reg [WIDTH-1:0] mem_wdata_q,
    output reg mem_write_q,
    output reg carry_q,
    output reg carry_write_q
);
    // ----------------------------------------
    // reset synchroniser
    // ----------------------------------------
    // nrst may rise anywhere in a cycle; the second flop hides that from the datapath
    reg rst_meta_q;
    reg rst_sync_q;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= `BRU_BIT_RESET;
            rst_sync_q <= `BRU_BIT_RESET;
        end else begin
            rst_meta_q <= 1'h1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    reg through_carry;
    reg dir_right;
    reg to_acc;
    reg to_mem;
    reg flag_upd;
    reg legal;

    always @* begin
        through_carry = 1'h0;
        dir_right = 1'h0;
        to_acc = 1'h0;
        to_mem = 1'h0;
        flag_upd = 1'h0;
        legal = 1'h1;
        case (op_sel)
            `BRU_OP_LEFT_TO_ACC: begin
                to_acc = 1'h1;
            end
            `BRU_OP_LEFT_CARRY: begin
                through_carry = 1'h1;
                to_mem = 1'h1;
                flag_upd = 1'h1;
            end
            `BRU_OP_LEFT_CARRY_TO_ACC: begin
                through_carry = 1'h1;
                to_acc = 1'h1;
                flag_upd = 1'h1;
            end
            `BRU_OP_RIGHT_IN_PLACE: begin
                dir_right = 1'h1;
                to_mem = 1'h1;
            end
            `BRU_OP_RIGHT_TO_ACC: begin
                dir_right = 1'h1;
                to_acc = 1'h1;
            end
            `BRU_OP_RIGHT_CARRY: begin
                dir_right = 1'h1;
                through_carry = 1'h1;
                to_mem = 1'h1;
                flag_upd = 1'h1;
            end
            default: begin
                // unused codes do nothing rather than guess a variant
                legal = 1'h0;
            end
        endcase
    end

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    wire [WIDTH-1:0] rot_result;
    wire rot_carry;

    // one rotator serves all six ops; only dir_right, through_carry and the routing below differ
    bru_rotator #(
        .WIDTH(WIDTH)
    ) u_rot (
        .operand(mem_operand),
        .carry_in(carry_flag),
        .through_carry(through_carry),
        .dir_right(dir_right),
        .result(rot_result),
        .carry_out(rot_carry)
    );

    // ----------------------------------------
    // request qualification
    // ----------------------------------------
    // op_valid may stay high: each edge with a legal code is one rotation step
    wire go;
    wire accum_load;
    wire mem_load;
    wire carry_load;

    assign go = op_valid & legal;
    assign accum_load = go & to_acc;
    assign mem_load = go & to_mem;
    assign carry_load = go & flag_upd;

    // ----------------------------------------
    // next values
    // ----------------------------------------
    reg [WIDTH-1:0] accum_d;
    reg [WIDTH-1:0] mem_wdata_d;
    reg carry_d;
    reg accum_write_d;
    reg mem_write_d;
    reg carry_write_d;

    always @* begin
        accum_d = accumulator_register;
        if (accum_load) begin
            accum_d = rot_result;
        end
    end

    always @* begin
        mem_wdata_d = mem_wdata_q;
        if (mem_load) begin
            mem_wdata_d = rot_result;
        end
    end

    // carry load select
    // flagless ops leave carry_q holding the last written value
    always @* begin
        carry_d = carry_q;
        if (carry_load) begin
            carry_d = rot_carry;
        end
    end

    always @* begin
        accum_write_d = accum_load;
        mem_write_d = mem_load;
        carry_write_d = carry_load;
    end

    // ----------------------------------------
    // accumulator register
    // ----------------------------------------
    // accumulator update strobe
    always @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            accumulator_register <= `BRU_BYTE_RESET;
            acc_write_q <= `BRU_BIT_RESET;
        end else begin
            accumulator_register <= accum_d;
            acc_write_q <= accum_write_d;
        end
    end

    // ----------------------------------------
    // memory write-back
    // ----------------------------------------
    // the write-back byte holds, so the core may pick it up a cycle late
    // write-back strobe
    always @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            mem_wdata_q <= `BRU_BYTE_RESET;
            mem_write_q <= `BRU_BIT_RESET;
        end else begin
            mem_wdata_q <= mem_wdata_d;
            mem_write_q <= mem_write_d;
        end
    end

    // ----------------------------------------
    // carry flag
    // ----------------------------------------
    // carry update strobe
    always @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            carry_q <= `BRU_BIT_RESET;
            carry_write_q <= `BRU_BIT_RESET;
        end else begin
            carry_q <= carry_d;
            carry_write_q <= carry_write_d;
        end
    end
endmodule

// ==== bru_defs.vh ====
`ifndef BRU_DEFS_VH
`define BRU_DEFS_VH

// operation select codes
`define BRU_OP_W 3
`define BRU_OP_LEFT_TO_ACC 3'h0
`define BRU_OP_LEFT_CARRY 3'h1
`define BRU_OP_LEFT_CARRY_TO_ACC 3'h2
`define BRU_OP_RIGHT_IN_PLACE 3'h3
`define BRU_OP_RIGHT_TO_ACC 3'h4
`define BRU_OP_RIGHT_CARRY 3'h5

// byte geometry
`define BRU_TOP_BIT 7
`define BRU_BOT_BIT 0
`define BRU_BYTE_RESET 8'h00
`define BRU_BIT_RESET 1'h0

`endif

// ==== bru_rotator.v ====
`timescale 1ns/1ps
`include "bru_defs.vh"

// ----------------------------------------
// combinational one-step rotator
// ----------------------------------------
module bru_rotator #(
    parameter WIDTH = 8
) (
    input wire [WIDTH-1:0] operand,
    input wire carry_in,
    input wire through_carry,
    input wire dir_right,
    output reg [WIDTH-1:0] result,
    output reg carry_out
);
    always @* begin
        result = operand;
        carry_out = carry_in;
        if (dir_right) begin
            result = {(through_carry ? carry_in : operand[`BRU_BOT_BIT]),
                      operand[WIDTH-1:`BRU_BOT_BIT+1]};
            if (through_carry) begin
                carry_out = operand[`BRU_BOT_BIT];
            end
        end else begin
            result = {operand[WIDTH-2:`BRU_BOT_BIT],
                      (through_carry ? carry_in : operand[WIDTH-1])};
            if (through_carry) begin
                carry_out = operand[WIDTH-1];
            end
        end
    end
endmodule

// ==== bru_chk_assertions.sv ====
`timescale 1ns/1ps
module bru_chk (
    input wire clk,
    input wire nrst,
    input wire op_valid,
    input wire [2:0] op_sel,
    input wire [7:0] mem_operand,
    input wire carry_flag,
    input wire [7:0] accumulator_register,
    input wire acc_write_q,
    input wire [7:0] mem_wdata_q,
    input wire mem_write_q,
    input wire carry_q,
    input wire carry_write_q
);
    logic [12:0] p_q;
    always_ff @(posedge clk) p_q <= {op_valid, op_sel, mem_operand, carry_flag};
    wire [3:0] k = p_q[12:9];
    wire [7:0] m = p_q[8:1], a = accumulator_register, d = mem_wdata_q;
    wire [2:0] w = {acc_write_q, mem_write_q, carry_write_q};
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_left_acc: assert property (k == 4'h8 |-> w == 3'h4 && a == {m[6:0], m[7]})
        else $error("bad");
    a_left_carry: assert property (k == 4'h9 |-> w == 3'h3 && {carry_q, d} == p_q[8:0])
        else $error("bad");
    a_carry_acc: assert property (k == 4'hA |-> w == 3'h5 && {carry_q, a} == p_q[8:0])
        else $error("bad");
    a_right_mem: assert property (k == 4'hB |-> w == 3'h2 && d == {m[0], m[7:1]})
        else $error("bad");
    a_right_acc: assert property (k == 4'hC |-> w == 3'h4 && a == {m[0], m[7:1]})
        else $error("bad");
    a_right_carry: assert property (k == 4'hD |-> w == 3'h3 && d == {p_q[0], m[7:1]})
        else $error("bad");
    a_carry_out: assert property (k == 4'hD |-> carry_q == m[0])
        else $error("bad");
    a_no_stray: assert property (!k[3] || k[2:0] > 3'h5 |-> w == 3'h0)
        else $error("bad");
endmodule
bind bru_byte_rotate_unit bru_chk u_chk (
    .clk(clk),
    .nrst(nrst),
    .op_valid(op_valid),
    .op_sel(op_sel),
    .mem_operand(mem_operand),
    .carry_flag(carry_flag),
    .accumulator_register(accumulator_register),
    .acc_write_q(acc_write_q),
    .mem_wdata_q(mem_wdata_q),
    .mem_write_q(mem_write_q),
    .carry_q(carry_q),
    .carry_write_q(carry_write_q)
);

// ==== bru_byte_rotate_unit_tb_top.sv ====
`timescale 1ns/1ps
module bru_byte_rotate_unit_tb_top;
    logic clk = 1'h0, nrst = 1'h0, op_valid = 1'h0, carry_flag = 1'h0;
    logic [2:0] op_sel = 3'h0;
    logic [7:0] mem_operand = 8'h00, accumulator_register, mem_wdata_q;
    logic acc_write_q, mem_write_q, carry_q, carry_write_q;
    int err_count = 0, compares = 0;
    logic [7:0] accum_exp = 8'h00, mem_exp = 8'h00;
    logic car_exp = 1'h0;
    bru_byte_rotate_unit uut (
        .clk(clk),
        .nrst(nrst),
        .op_valid(op_valid),
        .op_sel(op_sel),
        .mem_operand(mem_operand),
        .carry_flag(carry_flag),
        .accumulator_register(accumulator_register),
        .acc_write_q(acc_write_q),
        .mem_wdata_q(mem_wdata_q),
        .mem_write_q(mem_write_q),
        .carry_q(carry_q),
        .carry_write_q(carry_write_q)
    );
    initial forever #10 clk = ~clk;
    task chk(input [8:0] seen, exp);
        compares++;
        err_count += seen !== exp;
        if (seen !== exp) $display("[ERR] %0t mismatch", $time);
    endtask
    // e carries {new carry, result byte}; outputs not written must hold their last value
    task look(input [2:0] w, input [8:0] e);
        if (w[2]) accum_exp = e[7:0];
        if (w[1]) mem_exp = e[7:0];
        if (w[0]) car_exp = e[8];
        chk({6'h00, acc_write_q, mem_write_q, carry_write_q}, {6'h00, w});
        chk({carry_q, accumulator_register}, {car_exp, accum_exp});
        chk({1'h0, mem_wdata_q}, {1'h0, mem_exp});
    endtask
    task op(input [2:0] s, input [7:0] m, input c, input [2:0] w, input [8:0] e);
        @(posedge clk) {op_valid, op_sel, mem_operand, carry_flag} <= {1'h1, s, m, c};
        @(posedge clk) op_valid <= 1'h0;
        #1;
        look(w, e);
    endtask
    task s_left;
        op(3'h0, 8'h81, 1'h1, 3'h4, 9'h003);
        op(3'h1, 8'h81, 1'h0, 3'h3, 9'h102);
        op(3'h2, 8'h40, 1'h1, 3'h5, 9'h081);
    endtask
    // ignored code last: the held write data must still show the previous result
    task s_right;
        op(3'h5, 8'h01, 1'h0, 3'h3, 9'h100);
        op(3'h4, 8'h02, 1'h1, 3'h4, 9'h001);
        op(3'h3, 8'h01, 1'h1, 3'h2, 9'h080);
        op(3'h6, 8'h55, 1'h1, 3'h0, 9'h080);
        op(3'h7, 8'hAA, 1'h0, 3'h0, 9'h080);
    endtask
    // strobe held high: two requests taken on consecutive edges
    task s_burst;
        op_sel <= 3'h4;
        @(posedge clk) {op_valid, op_sel, mem_operand, carry_flag} <= {1'h1, 3'h4, 8'h03, 1'h0};
        @(posedge clk) {op_sel, mem_operand, carry_flag} <= {3'h1, 8'h80, 1'h1};
        #1;
        look(3'h4, 9'h081);
        @(posedge clk) op_valid <= 1'h0;
        #1;
        look(3'h3, 9'h101);
    endtask
    // reset in mid-run clears every output; first request after release
    task s_reset;
        @(posedge clk) nrst <= 1'h0;
        #1;
        {car_exp, accum_exp, mem_exp} = 17'h00000;
        look(3'h0, 9'h000);
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        repeat (3) @(posedge clk);
        #1;
        look(3'h0, 9'h000);
        op(3'h0, 8'h01, 1'h0, 3'h4, 9'h002);
    endtask
    task report_and_stop;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        #1;
        look(3'h0, 9'h000);
        repeat (2) @(posedge clk);
        s_left;
        s_right;
        s_burst;
        s_reset;
        report_and_stop;
    end
    initial begin
        #20000 err_count++;
        report_and_stop;
    end
endmodule
